// ==== rtl/ssp_sram_port.sv ====
`timescale 1ns/1ps
// How it works
// - Every synchronous input is sampled on the rising clk_sys edge.
// - Address loads on any acting strobe, whether or not the chip enables are active.
// - Low two address bits seed the two-bit burst counter.
// - Counter steps when advance is low in a burst, otherwise holds.
// - Advance steps the internal address without any new external address.
// - A byte lane is written when its select and byte-write enable are low.
// - Global write low writes all lanes, ignoring selects and byte-write enable.
// - Processor strobe is ignored whenever chip enable one is high.
// - Selected only with enable one low, enable two high, enable three low.
// - Chip enables are evaluated only when a new address loads.
// - Output enable low drives the data pins; high releases them as inputs.
// - First read clock after deselect keeps the pins undriven despite output enable.
// - With both strobes low and enable one low only the processor strobe acts.
// - Static strap picks burst order: low linear, high interleaved.
// - Pins undriven during write data, first clock after deselect, and deselect.
// - Read data is the location addressed at the previous rising edge.
module ssp_sram_port #(
    parameter int ADDR_W = ssp_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Address and strobes
    input wire logic [ADDR_W-1:0] addr,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    // Chip enables
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    // Write enables
    input wire logic byte_write_en_n,
    input wire logic [ssp_pkg::LANES-1:0] byte_lane_sel_n,
    input wire logic global_write_n,
    // Asynchronous controls
    input wire logic out_enable_n,
    input wire logic burst_mode_strap,
    // Data pins
    input wire ssp_pkg::ssp_word_s data_in,
    output ssp_pkg::ssp_word_s data_out,
    output logic data_oe_n
);
    localparam int WORDS = 1 << ADDR_W;
    localparam int HI_W = ADDR_W - ssp_pkg::BURST_W;

    // Both burst orders wrap inside four addresses.
    function automatic logic [1:0] burst_low(input logic mode, input logic [1:0] start,
                                             input logic [1:0] cnt);
        if (mode == ssp_pkg::MODE_LINEAR) begin
            burst_low = start + cnt;
        end else begin
            burst_low = start ^ cnt;
        end
    endfunction

    ssp_pkg::ssp_word_s mem [WORDS];

    ssp_pkg::ssp_state_e state, next_state;
    logic [HI_W-1:0] addr_hi, next_addr_hi;
    logic [1:0] start_lo, next_start_lo;
    logic [1:0] cnt, next_cnt;
    logic burst_mode, next_burst_mode;
    logic mode_s1, mode_s2, oe_s1, oe_s2;
    ssp_pkg::ssp_word_s next_data_out;
    logic next_data_oe_n;

    logic ld_p, ld_c, load, csel;
    logic [ssp_pkg::LANES-1:0] wr_lanes;
    logic [ADDR_W-1:0] cur_addr;
    ssp_pkg::ssp_word_s wr_word;

    // Asynchronous pins pass two flip-flops; with the output register, output enable acts three clocks late.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_s1 <= ssp_pkg::MODE_RST;
            mode_s2 <= ssp_pkg::MODE_RST;
            oe_s1 <= 1'h1;
            oe_s2 <= 1'h1;
        end else begin
            mode_s1 <= burst_mode_strap;
            mode_s2 <= mode_s1;
            oe_s1 <= out_enable_n;
            oe_s2 <= oe_s1;
        end
    end

    always_comb begin
        // Processor strobe wins, but only with enable one low.
        ld_p = !proc_addr_strobe_n && !chip_sel1_n;
        ld_c = !ld_p && !ctrl_addr_strobe_n;
        load = ld_p || ld_c;
        csel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
        // Selection changes only on a load.
        next_state = state;
        if (load) begin
            next_state = csel ? ssp_pkg::SSP_ACTIVE : ssp_pkg::SSP_DESEL;
        end
        next_addr_hi = load ? addr[ADDR_W-1:ssp_pkg::BURST_W] : addr_hi;
        next_start_lo = load ? addr[1:0] : start_lo;
        next_cnt = cnt;
        if (load) begin
            next_cnt = ssp_pkg::CNT_RST;
        end else if (state == ssp_pkg::SSP_ACTIVE && !burst_advance_n) begin
            next_cnt = cnt + ssp_pkg::CNT_STEP;
        end
        // Burst order taken with each new address.
        // Holding it per burst keeps a strap glitch from reordering a burst midway.
        // Loads in the first two clocks after reset still see the reset order.
        next_burst_mode = load ? mode_s2 : burst_mode;
        cur_addr = {next_addr_hi, burst_low(next_burst_mode, next_start_lo, next_cnt)};
        // A processor-strobe cycle is always a read, so its write enables are ignored.
        wr_lanes = ssp_pkg::NO_LANES;
        if (next_state == ssp_pkg::SSP_ACTIVE && !ld_p) begin
            if (!global_write_n) begin
                wr_lanes = ssp_pkg::ALL_LANES;
            end else if (!byte_write_en_n) begin
                wr_lanes = ~byte_lane_sel_n;
            end
        end
        // Merge pin data into the addressed word lane by lane.
        wr_word = mem[cur_addr];
        for (int i = 0; i < ssp_pkg::LANES; i++) begin
            if (wr_lanes[i]) begin
                wr_word.parity_io[i] = data_in.parity_io[i];
                wr_word.data[i*ssp_pkg::LANE_W +: ssp_pkg::LANE_W] =
                    data_in.data[i*ssp_pkg::LANE_W +: ssp_pkg::LANE_W];
            end
        end
        // Flow-through read of the address just taken.
        next_data_out = mem[cur_addr];
        // Drive only on a selected read past its first clock.
        next_data_oe_n = !(next_state == ssp_pkg::SSP_ACTIVE && state == ssp_pkg::SSP_ACTIVE
                           && wr_lanes == ssp_pkg::NO_LANES && !oe_s2);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ssp_pkg::SSP_DESEL;
            addr_hi <= '0;
            start_lo <= ssp_pkg::CNT_RST;
            cnt <= ssp_pkg::CNT_RST;
            burst_mode <= ssp_pkg::MODE_RST;
            data_out <= '0;
            data_oe_n <= 1'h1;
        end else begin
            // All synchronous inputs registered on the rising edge.
            state <= next_state;
            addr_hi <= next_addr_hi;
            start_lo <= next_start_lo;
            cnt <= next_cnt;
            burst_mode <= next_burst_mode;
            data_out <= next_data_out;
            data_oe_n <= next_data_oe_n;
        end
    end

    // The array has no reset; its contents are undefined until written.
    always_ff @(posedge clk_sys) begin
        if (wr_lanes != ssp_pkg::NO_LANES) begin
            mem[cur_addr] <= wr_word;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_addr_load: assert property (load && csel |=>
        addr_hi == $past(addr[ADDR_W-1:ssp_pkg::BURST_W]) && start_lo == $past(addr[1:0]))
        else $error("address not loaded on strobe");
    chk_proc_ignored: assert property (
        !proc_addr_strobe_n && chip_sel1_n && ctrl_addr_strobe_n |=> $stable(state)
        && $stable(addr_hi)) else $error("processor strobe acted with enable one high");
    chk_burst_step: assert property (
        state == ssp_pkg::SSP_ACTIVE && !load && !burst_advance_n |=> cnt == $past(cnt) + 2'h1)
        else $error("burst counter did not step");
    chk_burst_hold: assert property (!load && burst_advance_n |=> $stable(cnt))
        else $error("burst counter moved without advance");
    chk_desel_decode: assert property (load && !csel |=> state == ssp_pkg::SSP_DESEL)
        else $error("load with inactive enables did not deselect");
    chk_sel_kept: assert property (!load |=> $stable(state))
        else $error("selection changed without a load");
    chk_write_quiet: assert property (wr_lanes != ssp_pkg::NO_LANES |=> data_oe_n)
        else $error("pins driven during write data");
    chk_first_read: assert property (
        state == ssp_pkg::SSP_ACTIVE && $past(state) == ssp_pkg::SSP_DESEL |-> data_oe_n)
        else $error("pins driven on first clock after deselect");
    chk_global_all: assert property (
        next_state == ssp_pkg::SSP_ACTIVE && !ld_p && !global_write_n |-> wr_lanes == 4'hf)
        else $error("global write missed a lane");
    chk_proc_read: assert property (ld_p |-> wr_lanes == ssp_pkg::NO_LANES)
        else $error("processor strobe cycle wrote");
    chk_oe_release: assert property (oe_s2 |=> data_oe_n)
        else $error("pins driven with output enable high");
    chk_burst_seed: assert property (load |=>
        cnt == ssp_pkg::CNT_RST && start_lo == $past(addr[1:0]))
        else $error("burst counter not seeded on load");
    chk_idle_hold: assert property (
        state == ssp_pkg::SSP_DESEL && !load |=> $stable(cnt))
        else $error("burst counter moved while deselected");
    chk_desel_no_write: assert property (
        next_state == ssp_pkg::SSP_DESEL |-> wr_lanes == ssp_pkg::NO_LANES)
        else $error("write while deselected");
    chk_desel_quiet: assert property (state == ssp_pkg::SSP_DESEL |-> data_oe_n)
        else $error("pins driven while deselected");
    chk_order_kept: assert property (!load |=> $stable(burst_mode))
        else $error("burst order changed inside a burst");
    chk_oe_drive: assert property (
        state == ssp_pkg::SSP_ACTIVE && !load && wr_lanes == ssp_pkg::NO_LANES && !oe_s2
        |=> !data_oe_n) else $error("selected read left the pins undriven");
    chk_lane_select: assert property (
        next_state == ssp_pkg::SSP_ACTIVE && !ld_p && global_write_n && !byte_write_en_n
        |-> wr_lanes == ~byte_lane_sel_n) else $error("byte lanes not written as selected");
endmodule // ssp_sram_port

// ==== rtl/ssp_pkg.sv ====
package ssp_pkg;
    // Geometry of one memory word: four lanes, each one byte plus one parity bit.
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int ADDR_W = 18;
    localparam int BURST_W = 2;
    // Strap value held until the strap has been sampled after reset: interleaved.
    localparam logic MODE_RST = 1'h1;
    localparam logic MODE_LINEAR = 1'h0;
    localparam logic [3:0] ALL_LANES = 4'hf;
    localparam logic [3:0] NO_LANES = 4'h0;
    localparam logic [1:0] CNT_RST = 2'h0;
    localparam logic [1:0] CNT_STEP = 2'h1;

    typedef enum logic [1:0] {
        SSP_DESEL = 2'b01,
        SSP_ACTIVE = 2'b10
    } ssp_state_e;

    // One data word as it sits on the data and parity pins.
    typedef struct packed {
        logic [LANES-1:0] parity_io;
        logic [LANES*LANE_W-1:0] data;
    } ssp_word_s;
endpackage

// ==== bench/ssp_host_model.sv ====
`timescale 1ns/1ps
module ssp_host_model #(
    parameter int ADDR_W = 6
) (
    // Clock and device pins
    input wire logic clk_sys,
    input wire ssp_pkg::ssp_word_s data_out,
    input wire logic data_oe_n,
    // Bus controls
    output logic [ADDR_W-1:0] addr,
    output logic proc_addr_strobe_n,
    output logic ctrl_addr_strobe_n,
    output logic burst_advance_n,
    output logic chip_sel1_n,
    output logic chip_sel2,
    output logic chip_sel3_n,
    output logic byte_write_en_n,
    output logic [ssp_pkg::LANES-1:0] byte_lane_sel_n,
    output logic global_write_n,
    output logic out_enable_n = 1'h0,
    // Resolved data wire
    output ssp_pkg::ssp_word_s data_in
);
    logic drv = 1'h0;
    ssp_pkg::ssp_word_s wd = 36'h0;
    ssp_pkg::ssp_word_s last = 36'h0;
    // A released wire toggles, so stale bus data can never pass for read data.
    assign data_in = !data_oe_n ? data_out : (drv ? wd : ~last);
    always @(posedge clk_sys) begin
        last <= data_in;
    end
    task automatic op(input logic [4:0] c, input logic [2:0] ce, input logic [ADDR_W-1:0] a,
                      input logic [3:0] ln, input ssp_pkg::ssp_word_s d);
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = c[4:2];
        {global_write_n, byte_write_en_n} = c[1:0];
        {chip_sel1_n, chip_sel2, chip_sel3_n} = ce;
        addr = a;
        byte_lane_sel_n = ln;
        wd = d;
        drv = !c[1] || !c[0];
        @(posedge clk_sys);
        #1;
    endtask
    initial begin
        op(5'h1f, 3'h4, 6'h0, 4'hf, 36'h0); // Idle and deselected.
    end
endmodule // ssp_host_model

// ==== bench/ssp_sram_port_tb.sv ====
`timescale 1ns/1ps
module ssp_sram_port_tb;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic burst_mode_strap = 1'h0;
    logic [5:0] addr;
    logic ps_n, cs_n, advance_n, sel1_n, sel2, sel3_n, byte_wr_n, all_wr_n, oe_n, data_oe_n;
    logic [3:0] lane_n;
    ssp_pkg::ssp_word_s data_in, data_out;
    ssp_pkg::ssp_word_s mem [64];
    int err_total = 0;
    int n_checks = 0;
    always #2 clk_sys = ~clk_sys;
    ssp_sram_port #(.ADDR_W(6)) u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr),
        .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_n), .burst_advance_n(advance_n),
        .chip_sel1_n(sel1_n), .chip_sel2(sel2), .chip_sel3_n(sel3_n),
        .byte_write_en_n(byte_wr_n), .byte_lane_sel_n(lane_n), .global_write_n(all_wr_n),
        .out_enable_n(oe_n), .burst_mode_strap(burst_mode_strap), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n));
    ssp_host_model #(.ADDR_W(6)) u_host (.clk_sys(clk_sys), .data_out(data_out),
        .data_oe_n(data_oe_n), .addr(addr), .proc_addr_strobe_n(ps_n),
        .ctrl_addr_strobe_n(cs_n), .burst_advance_n(advance_n), .chip_sel1_n(sel1_n),
        .chip_sel2(sel2), .chip_sel3_n(sel3_n), .byte_write_en_n(byte_wr_n),
        .byte_lane_sel_n(lane_n), .global_write_n(all_wr_n), .out_enable_n(oe_n),
        .data_in(data_in));
    task automatic chk_word(input ssp_pkg::ssp_word_s e);
        n_checks++;
        if (data_out !== e) begin
            err_total++;
            $display("[FAIL] %0t read data %h, expected %h", $time, data_out, e);
        end
    endtask
    task automatic chk_oe(input logic e);
        n_checks++;
        if (data_oe_n !== e) begin
            err_total++;
            $display("[FAIL] %0t pin drive enable %b, expected %b", $time, data_oe_n, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input ssp_pkg::ssp_word_s d, input logic [3:0] ln,
                      input logic g);
        logic [3:0] m;
        m = g ? ln : 4'h0;
        for (int l = 0; l < 4; l++) begin
            if (!m[l]) begin
                mem[a].data[8*l+:8] = d.data[8*l+:8];
                mem[a].parity_io[l] = d.parity_io[l];
            end
        end
        u_host.op({3'h5, g, !g}, 3'h2, a, ln, d); // Write on a load.
        chk_oe(1'h1); // Undriven on a write edge.
    endtask
    task automatic rd_burst(input logic [5:0] a, input logic oe_x, input logic il);
        logic [5:0] b;
        u_host.op(5'h17, 3'h0, a, 4'h0, 36'h0); // Deselecting load.
        chk_oe(1'h1); // Deselected load.
        u_host.op(5'h17, 3'h2, a, 4'h0, 36'h0); // Selecting load.
        chk_oe(1'h1); // First clock after deselect.
        chk_word(mem[a]); // Start word.
        for (int i = 1; i < 4; i++) begin
            b = il ? {a[5:2], a[1:0] ^ 2'(i)} : {a[5:2], a[1:0] + 2'(i)};
            u_host.op(5'h0b, 3'h4, ~a, 4'h0, 36'h0); // Advance only.
            chk_oe(oe_x); // Selection kept.
            chk_word(mem[b]); // Burst step.
        end
    endtask
    task automatic wr_burst(input logic [5:0] a);
        for (int i = 0; i < 4; i++) begin
            mem[{a[5:2], a[1:0] + 2'(i)}] = {4'(i), 24'h5a5a00, 2'(i), a};
        end
        u_host.op(5'h15, 3'h2, a, 4'hf, mem[a]); // Load and write.
        chk_oe(1'h1); // Write data edge.
        for (int i = 1; i < 4; i++) begin
            u_host.op(5'h19, 3'h4, ~a, 4'hf, mem[{a[5:2], a[1:0] + 2'(i)}]); // Step.
            chk_oe(1'h1); // Still a write edge.
        end
    endtask
    task automatic proc_rd();
        u_host.op(5'h05, 3'h2, 6'h0a, 4'h0, {4'h0, 32'hdead_beef}); // Both strobes.
        chk_oe(1'h0); // Processor strobe read.
        chk_word(mem[10]); // Reads word ten.
    endtask
    task automatic reset_mid();
        u_host.out_enable_n = 1'h0;
        burst_mode_strap = 1'h1;
        rst = 1'h1;
        @(posedge clk_sys);
        #1;
        chk_oe(1'h1); // Undriven while in reset.
        chk_word(36'h0); // Read data cleared in reset.
        rst = 1'h0;
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #1000;
        err_total++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'h0;
        for (int i = 8; i < 12; i++) begin
            wr(6'(i), {4'(i), 32'h1234_0000 | 32'(i)}, 4'hf, 1'h0); // Global.
        end
        wr(6'h09, {4'h5, 32'ha5a5_a5a5}, 4'ha, 1'h1); // Lanes zero and two.
        wr_burst(6'h0c); // Burst of writes.
        proc_rd(); // Both strobes low.
        rd_burst(6'h09, 1'h0, 1'h0); // Wraps past the end.
        u_host.out_enable_n = 1'h1;
        rd_burst(6'h0a, 1'h1, 1'h0); // Released by enable.
        reset_mid(); // Strap high, second reset.
        rd_burst(6'h09, 1'h0, 1'h1); // Interleaved wrap.
        rd_burst(6'h0f, 1'h0, 1'h1); // Burst-written words.
        results();
    end
endmodule // ssp_sram_port_tb
